//--- hdl/mcs_defs.vh
/*
 constants of the monitor control block: register offsets, control bit
 positions, power-on values, soft-reset address ranges, serial address.
 assumes inclusion by every design file of the block except the pin 42 controller.
*/
`ifndef MCS_DEFS_VH
`define MCS_DEFS_VH
`define MCS_REG_MAIN      8'h00
`define MCS_REG_FDIV_A    8'h02
`define MCS_REG_FDIV_B    8'h03
`define MCS_REG_DAC       8'h04
`define MCS_REG_PWM       8'h05
`define MCS_REG_AUX       8'h07
`define MCS_REG_GPIO_CFG  8'h08
`define MCS_REG_THR_INT   8'h0d
`define MCS_REG_THR_EXT1  8'h0e
`define MCS_REG_STAT4     8'h23
`define MCS_DEF_FDIV      8'h55
`define MCS_DEF_FULL      8'hff
`define MCS_DEF_THR_INT   8'h37
`define MCS_DEF_THR_EXT1  8'h50
`define MCS_DEF_ZERO      8'h00
`define MCS_MAIN_RUN      0
`define MCS_MAIN_ALERT_EN 1
`define MCS_MAIN_ALERT_CLR 2
`define MCS_MAIN_SHARED   3
`define MCS_MAIN_OVH_EN   4
`define MCS_MAIN_AFC_DAC  5
`define MCS_MAIN_AFC_PWM  6
`define MCS_MAIN_SOFT     7
`define MCS_AUX_P42_GPIO  0
`define MCS_AUX_CI_CLR    1
`define MCS_AUX_VREF      2
`define MCS_AUX_G16_DIR   6
`define MCS_AUX_G16_POL   7
`define MCS_STAT4_CI      6
`define MCS_STAT4_G16     7
`define MCS_SOFT_A_LO     8'h01
`define MCS_SOFT_A_HI     8'h0b
`define MCS_SOFT_B_LO     8'h18
`define MCS_SOFT_B_HI     8'h3f
`define MCS_SOFT_C_LO     8'h6e
`define MCS_SOFT_C_HI     8'h6f
`define MCS_SLAVE_ADDR    7'h2c
`endif

//--- hdl/mcs_serial_slave.v
/*
 two-wire serial slave: address byte, pointer byte, then data bytes
 written or read at an auto-incrementing pointer.
 assumes scl and sda sampled synchronously to sys_clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mcs_defs.vh"
module mcs_serial_slave (
   input  wire       sys_clk_in,
   input  wire       reset_in,
   input  wire       scl_in,
   input  wire       sda_in,
   input  wire [7:0] rd_data_in,
   output wire [7:0] rd_addr_out,
   output reg        sda_oe_n_out,
   output reg        wr_stb_out,
   output reg  [7:0] wr_addr_out,
   output reg  [7:0] wr_data_out
);
   localparam [4:0] S_IDLE = 5'b00001;
   localparam [4:0] S_RX   = 5'b00010;
   localparam [4:0] S_ACK  = 5'b00100;
   localparam [4:0] S_TX   = 5'b01000;
   localparam [4:0] S_RACK = 5'b10000;
   reg  [4:0] st_q;
   reg  [7:0] sh_q;
   reg  [3:0] cnt_q;
   reg  [1:0] idx_q;
   reg        rw_q;
   reg        scl_q;
   reg        sda_q;
   reg  [7:0] ptr_q;
   wire       scl_rise = scl_in & ~scl_q;
   wire       scl_fall = ~scl_in & scl_q;
   wire       start    = scl_in & scl_q & sda_q & ~sda_in;
   wire       stop     = scl_in & scl_q & ~sda_q & sda_in;
   assign rd_addr_out = ptr_q;
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         st_q <= S_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         idx_q <= 2'h0;
         rw_q <= 1'b0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         ptr_q <= 8'h00;
         sda_oe_n_out <= 1'b1;
         wr_stb_out <= 1'b0;
         wr_addr_out <= 8'h00;
         wr_data_out <= 8'h00;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         wr_stb_out <= 1'b0;
         if (start) begin
            st_q <= S_RX;
            cnt_q <= 4'h0;
            idx_q <= 2'h0;
            sda_oe_n_out <= 1'b1;
         end else if (stop) begin
            st_q <= S_IDLE;
            sda_oe_n_out <= 1'b1;
         end else begin
            case (st_q)
               S_RX: begin
                  if (scl_rise) begin
                     sh_q <= {sh_q[6:0], sda_in};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall && cnt_q == 4'h8) begin
                     if (idx_q == 2'h0) begin
                        rw_q <= sh_q[0];
                        st_q <= (sh_q[7:1] == `MCS_SLAVE_ADDR) ? S_ACK : S_IDLE;
                        sda_oe_n_out <= (sh_q[7:1] != `MCS_SLAVE_ADDR);
                     end else begin
                        st_q <= S_ACK;
                        sda_oe_n_out <= 1'b0;
                        if (idx_q == 2'h1) begin
                           ptr_q <= sh_q;
                        end else begin
                           wr_stb_out <= 1'b1;
                           wr_addr_out <= ptr_q;
                           wr_data_out <= sh_q;
                           ptr_q <= ptr_q + 8'h01;
                        end
                     end
                     if (idx_q != 2'h2) idx_q <= idx_q + 2'h1;
                  end
               end
               S_ACK, S_RACK: begin
                  if (st_q == S_RACK && scl_rise && sda_in) begin
                     st_q <= S_IDLE;
                  end else if (scl_fall) begin
                     if (rw_q) begin
                        sh_q <= {rd_data_in[6:0], 1'b0};
                        sda_oe_n_out <= rd_data_in[7];
                        cnt_q <= 4'h1;
                        st_q <= S_TX;
                     end else begin
                        sda_oe_n_out <= 1'b1;
                        cnt_q <= 4'h0;
                        st_q <= S_RX;
                     end
                  end
               end
               S_TX: begin
                  if (scl_fall && cnt_q == 4'h8) begin
                     sda_oe_n_out <= 1'b1;
                     ptr_q <= ptr_q + 8'h01;
                     st_q <= S_RACK;
                  end else if (scl_fall) begin
                     sda_oe_n_out <= sh_q[7];
                     sh_q <= {sh_q[6:0], 1'b0};
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
               S_IDLE: st_q <= S_IDLE;
               default: st_q <= S_IDLE;
            endcase
         end
      end
   end
endmodule // mcs_serial_slave
`default_nettype wire

//--- hdl/mcs_pin42_ctrl.v
/*
 shared pin 42: overheat alarm (bidirectional) or general-purpose pin.
 assumes the pin is open drain; pin_in is the wire level, synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module mcs_pin42_ctrl (
   input  wire sys_clk_in,
   input  wire reset_in,
   input  wire gpio_mode_in,
   input  wire gpio_dir_in,
   input  wire gpio_pol_in,
   input  wire gpio_data_in,
   input  wire alarm_en_in,
   input  wire alarm_req_in,
   input  wire pin_in,
   output reg  pin_oe_n_out,
   output reg  fan_full_out,
   output reg  gpio_hit_out
);
   wire alarm_drive = alarm_en_in & alarm_req_in;
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         pin_oe_n_out <= 1'b1;
         fan_full_out <= 1'b0;
         gpio_hit_out <= 1'b0;
      end else if (gpio_mode_in) begin
         // outputs only when direction says so; low level is the driven one
         pin_oe_n_out <= ~(gpio_dir_in & (gpio_data_in ^ gpio_pol_in));
         fan_full_out <= alarm_drive;
         gpio_hit_out <= ~gpio_dir_in & ~(pin_in ^ gpio_pol_in);
      end else begin
         pin_oe_n_out <= ~alarm_drive;
         // an external low on the pin also forces full cooling
         fan_full_out <= alarm_drive | ~pin_in;
         gpio_hit_out <= 1'b0;
      end
   end
endmodule // mcs_pin42_ctrl
`default_nettype wire

//--- hdl/mcs_monitor_ctrl.v
/*
 control and register bank of the monitor: 256 byte registers reached by
 the two-wire serial bus, run/low-power control, alert output gating,
 pin function selects, intrusion latch, software reset.
 assumes all pin inputs synchronous to sys_clk_in; open-drain pins are
 resolved outside from the _oe_n outputs.
*/
// Functional notes
// R1: power-on reset returns every register to its default; no nonvolatile store here.
// R2: after power-on reset every general-purpose pin is an input.
// R3: main bit0 one runs the loop; zero stops it, low power, converter off.
// R4: serial reads and writes work in low power mode.
// R5: main bit1 enables the alert output.
// R6: writing main bit2 one clears alert, status and pins untouched.
// R7: main bit3 selects remote channel two or two extra analog inputs.
// R8: main bit4 enables the overheat alarm output.
// R9: main bit5 gives the analog fan output to automatic control.
// R10: main bit6 gives the pulse-width fan output to automatic control.
// R11: writing main bit7 one starts a software reset.
// R12: host clears the software reset bit by writing zero.
// R13: software reset restores registers 01h to 0Bh.
// R14: software reset restores masks, offset and status 18h to 25h.
// R15: software reset clears value registers 1Fh and 20h to 3Fh.
// R16: software reset restores remote offsets 6Eh and 6Fh.
// R17: limit registers keep their values over a software reset.
// R18: aux bit0 makes pin 42 general-purpose, else overheat alarm.
// R19: aux bit1 clears intrusion latch; host must write zero to rearm.
// R20: aux bit2 selects 2.5 V reference, else 1.82 V.
// R21: aux bits 6,7 set pin sixteen direction and polarity; 3-5 unused.
// R22: analog and fan sequences start together, then run unsynchronised.
// R23: main rail reset pin low restores the software reset set.
`timescale 1ns/1ps
`default_nettype none
`include "mcs_defs.vh"
module mcs_monitor_ctrl (
   input  wire        sys_clk_in,
   input  wire        reset_in,
   input  wire        main_rail_reset_n_in,
   input  wire        scl_in,
   input  wire        sda_in,
   output reg         sda_out,
   output wire        sda_oe_n_out,
   input  wire        alert_event_in,
   output reg         alert_n_out,
   input  wire        overheat_req_in,
   input  wire        pin42_in,
   output reg         pin42_out,
   output wire        pin42_oe_n_out,
   output wire        fan_full_speed_out,
   input  wire        chassis_intrusion_in,
   output reg         monitor_run_out,
   output reg         low_power_out,
   output reg         adc_enable_out,
   output reg         loop_start_out,
   output reg         shared_pins_analog_out,
   output reg         overheat_en_out,
   output reg         afc_analog_out,
   output reg         afc_pwm_out,
   output reg         vref_2v5_sel_out,
   output reg  [15:0] gpio_oe_n_out
);

   // power-on value of each register
   function [7:0] def_val;
      input integer a;
      begin
         if (a == `MCS_REG_FDIV_A || a == `MCS_REG_FDIV_B) begin
            def_val = `MCS_DEF_FDIV;
         end else if (a == `MCS_REG_DAC || a == `MCS_REG_PWM) begin
            def_val = `MCS_DEF_FULL;
         end else if (a == `MCS_REG_THR_INT) begin
            def_val = `MCS_DEF_THR_INT;
         end else if (a == `MCS_REG_THR_EXT1) begin
            def_val = `MCS_DEF_THR_EXT1;
         end else begin
            def_val = `MCS_DEF_ZERO;
         end
      end
   endfunction

   // members of the software reset set; limits stay out  [R17]
   function soft_sel;
      input integer a;
      begin
         if (a >= `MCS_SOFT_A_LO && a <= `MCS_SOFT_A_HI) begin
            soft_sel = 1'b1; // [R13]
         end else if (a >= `MCS_SOFT_B_LO && a <= `MCS_SOFT_B_HI) begin
            soft_sel = 1'b1; // [R14] [R15]
         end else if (a >= `MCS_SOFT_C_LO && a <= `MCS_SOFT_C_HI) begin
            soft_sel = 1'b1; // [R16]
         end else begin
            soft_sel = 1'b0;
         end
      end
   endfunction

   wire [7:0]    rd_addr;
   wire          wr_stb;
   wire [7:0]    wr_addr;
   wire [7:0]    wr_data;
   wire [2047:0] regs_flat;
   reg  [7:0]    rd_data;
   reg           soft_q;
   reg           pend_q;
   reg           ci_q;
   reg           run_prev_q;
   wire          gpio_hit;
   wire [7:0]    main_q = regs_flat[7:0];
   wire [7:0]    aux_q  = regs_flat[`MCS_REG_AUX*8 +: 8];
   wire [7:0]    stat4_q = regs_flat[`MCS_REG_STAT4*8 +: 8];
   wire          main_wr = wr_stb && wr_addr == `MCS_REG_MAIN;

   // bus access never looks at the run bit, so low power keeps it alive
   mcs_serial_slave u_slave (
      .sys_clk_in   (sys_clk_in),
      .reset_in     (reset_in),
      .scl_in       (scl_in),
      .sda_in       (sda_in),
      .rd_data_in   (rd_data),
      .rd_addr_out  (rd_addr),
      .sda_oe_n_out (sda_oe_n_out),
      .wr_stb_out   (wr_stb),
      .wr_addr_out  (wr_addr),
      .wr_data_out  (wr_data)
   ); // [R4]

   // software reset strobe: bit7 write or main rail reset pin held low
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         soft_q <= 1'b0;
      end else begin
         soft_q <= (main_wr & wr_data[`MCS_MAIN_SOFT]) | ~main_rail_reset_n_in; // [R11] [R23]
      end
   end

   // register array; soft reset wins over a write landing in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < 256; gi = gi + 1) begin : g_reg
         reg [7:0] val_q;
         always @(posedge sys_clk_in) begin
            if (reset_in) begin
               val_q <= def_val(gi); // [R1] [R2]
            end else if (soft_q && soft_sel(gi)) begin
               val_q <= def_val(gi); // [R13] [R14] [R15] [R16]
            end else if (wr_stb && wr_addr == gi[7:0]) begin
               // main bit7 stays set until the host writes zero  [R12]
               val_q <= wr_data;
            end
         end
         assign regs_flat[gi*8 +: 8] = val_q;
      end
   endgenerate

   // read mux; live status bits are overlaid on the stored byte
   always @* begin
      rd_data = regs_flat[{rd_addr, 3'b000} +: 8];
      if (rd_addr == `MCS_REG_STAT4) begin
         rd_data[`MCS_STAT4_CI] = ci_q;
         rd_data[`MCS_STAT4_G16] = gpio_hit | stat4_q[`MCS_STAT4_G16];
      end else if (rd_addr == `MCS_REG_AUX) begin
         rd_data[5:3] = 3'b000; // [R21]
      end
   end

   // alert latch: new event wins over a clear in the same cycle
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         pend_q <= 1'b0;
      end else if (alert_event_in) begin
         pend_q <= 1'b1;
      end else if (main_wr && wr_data[`MCS_MAIN_ALERT_CLR]) begin
         pend_q <= 1'b0; // [R6]
      end
   end

   // intrusion latch: clear bit held high keeps it empty
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         ci_q <= 1'b0;
      end else if (aux_q[`MCS_AUX_CI_CLR] || soft_q) begin
         ci_q <= 1'b0; // [R19]
      end else if (chassis_intrusion_in) begin
         ci_q <= 1'b1;
      end
   end

   // control outputs straight from flops
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         sda_out <= 1'b0;
         pin42_out <= 1'b0;
         alert_n_out <= 1'b1;
         monitor_run_out <= 1'b0;
         low_power_out <= 1'b1;
         adc_enable_out <= 1'b0;
         loop_start_out <= 1'b0;
         run_prev_q <= 1'b0;
         shared_pins_analog_out <= 1'b0;
         overheat_en_out <= 1'b0;
         afc_analog_out <= 1'b0;
         afc_pwm_out <= 1'b0;
         vref_2v5_sel_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         pin42_out <= 1'b0;
         // output only drives while enabled and clear is low  [R5] [R6]
         alert_n_out <= ~(pend_q & main_q[`MCS_MAIN_ALERT_EN]
                          & ~main_q[`MCS_MAIN_ALERT_CLR]);
         monitor_run_out <= main_q[`MCS_MAIN_RUN]; // [R3]
         low_power_out <= ~main_q[`MCS_MAIN_RUN]; // [R3]
         adc_enable_out <= main_q[`MCS_MAIN_RUN]; // [R3]
         run_prev_q <= main_q[`MCS_MAIN_RUN];
         // one start pulse for both sequences; after that they drift  [R22]
         loop_start_out <= main_q[`MCS_MAIN_RUN] & ~run_prev_q;
         shared_pins_analog_out <= main_q[`MCS_MAIN_SHARED]; // [R7]
         overheat_en_out <= main_q[`MCS_MAIN_OVH_EN]; // [R8]
         afc_analog_out <= main_q[`MCS_MAIN_AFC_DAC]; // [R9]
         afc_pwm_out <= main_q[`MCS_MAIN_AFC_PWM]; // [R10]
         vref_2v5_sel_out <= aux_q[`MCS_AUX_VREF]; // [R20]
      end
   end

   // general pins: even config bits are direction, one means output
   wire [15:0] gpio_oe_n_d;
   genvar gk;
   generate
      for (gk = 0; gk < 16; gk = gk + 1) begin : g_gpio
         assign gpio_oe_n_d[gk] = ~regs_flat[(`MCS_REG_GPIO_CFG + gk/4)*8 + (gk%4)*2];
      end
   endgenerate
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         gpio_oe_n_out <= 16'hffff; // [R2]
      end else begin
         gpio_oe_n_out <= gpio_oe_n_d;
      end
   end

   mcs_pin42_ctrl u_pin42 (
      .sys_clk_in   (sys_clk_in),
      .reset_in     (reset_in),
      .gpio_mode_in (aux_q[`MCS_AUX_P42_GPIO]),
      .gpio_dir_in  (aux_q[`MCS_AUX_G16_DIR]),
      .gpio_pol_in  (aux_q[`MCS_AUX_G16_POL]),
      .gpio_data_in (stat4_q[`MCS_STAT4_G16]),
      .alarm_en_in  (main_q[`MCS_MAIN_OVH_EN]),
      .alarm_req_in (overheat_req_in),
      .pin_in       (pin42_in),
      .pin_oe_n_out (pin42_oe_n_out),
      .fan_full_out (fan_full_speed_out),
      .gpio_hit_out (gpio_hit)
   ); // [R18] [R21] [R8]

endmodule // mcs_monitor_ctrl
`default_nettype wire

//--- dv/mcs_chk.sv
/* port checker for the monitor control block.
   assumes bind onto mcs_monitor_ctrl, one clock, reset_in high sync. */
`timescale 1ns/1ps
`default_nettype none
module mcs_chk (
   input wire logic        sys_clk_in,
   input wire logic        reset_in,
   input wire logic        main_rail_reset_n_in,
   input wire logic        alert_event_in,
   input wire logic        overheat_req_in,
   input wire logic        pin42_in,
   input wire logic        alert_n_out,
   input wire logic        pin42_oe_n_out,
   input wire logic        fan_full_speed_out,
   input wire logic        monitor_run_out,
   input wire logic        low_power_out,
   input wire logic        adc_enable_out,
   input wire logic        loop_start_out,
   input wire logic [15:0] gpio_oe_n_out
);
   default clocking dc @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   logic seen_q;
   // sticky: alert has no cause before the first event
   always_ff @(posedge sys_clk_in) begin
      if (reset_in)
         seen_q <= 1'b0;
      else if (alert_event_in)
         seen_q <= 1'b1;
   end
   a_lowpwr_run_tie: assert property (low_power_out == !monitor_run_out)
      else $error("low power not inverse of run");
   a_adc_run_tie: assert property (adc_enable_out == monitor_run_out)
      else $error("converter enable differs from run");
   a_start_one_pulse: assert property (loop_start_out |=> !loop_start_out)
      else $error("loop start longer than one cycle");
   a_start_with_run: assert property (loop_start_out |-> ##[0:1] monitor_run_out)
      else $error("loop start without run");
   a_start_on_rise: assert property ($rose(monitor_run_out) |-> loop_start_out)
      else $error("run rose, no loop start");
   a_alert_needs_event: assert property (!alert_n_out |-> seen_q)
      else $error("alert low with no event");
   // three deep: drive and fan flag may each add a cycle
   a_fan_idle_pin: assert property (
      !$past(overheat_req_in) && !$past(overheat_req_in, 2) && !$past(overheat_req_in, 3)
      && $past(pin42_in) && $past(pin42_in, 2) |-> !fan_full_speed_out)
      else $error("fans forced with no overheat");
   a_reset_defaults: assert property ($fell(reset_in) |-> gpio_oe_n_out == 16'hffff
      && pin42_oe_n_out && low_power_out && alert_n_out)
      else $error("outputs not at defaults after reset");
   a_rail_gpio_input: assert property (!main_rail_reset_n_in [*5] |-> gpio_oe_n_out == 16'hffff)
      else $error("rail reset left a gpio driven");
endmodule // mcs_chk
bind mcs_monitor_ctrl mcs_chk u_chk (
   .sys_clk_in(sys_clk_in), .reset_in(reset_in), .main_rail_reset_n_in(main_rail_reset_n_in),
   .alert_event_in(alert_event_in), .overheat_req_in(overheat_req_in), .pin42_in(pin42_in),
   .alert_n_out(alert_n_out), .pin42_oe_n_out(pin42_oe_n_out),
   .fan_full_speed_out(fan_full_speed_out), .monitor_run_out(monitor_run_out),
   .low_power_out(low_power_out), .adc_enable_out(adc_enable_out),
   .loop_start_out(loop_start_out), .gpio_oe_n_out(gpio_oe_n_out)
);
`default_nettype wire

//--- dv/mcs_host_model.sv
/* two-wire bus host: start, stop, bytes, register write and read.
   assumes sda_in is the resolved wire with pull-up; moves on falling edges. */
`timescale 1ns/1ps
`default_nettype none
`include "mcs_defs.vh"
module mcs_host_model (
   input  wire logic sys_clk_in,
   input  wire logic sda_in,
   output var  logic scl_out,
   output var  logic sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // three cycles a phase: slave samples twice and answers one cycle late
   task automatic gap();
      repeat (3) @(negedge sys_clk_in);
   endtask
   task automatic send_bit(input logic b);
      sda_out = b;
      gap();
      scl_out = 1'b1;
      gap();
      scl_out = 1'b0;
      gap();
   endtask
   task automatic take_bit(output logic b);
      sda_out = 1'b1;
      gap();
      scl_out = 1'b1;
      gap();
      b = sda_in;
      scl_out = 1'b0;
      gap();
   endtask
   task automatic start();
      sda_out = 1'b1;
      gap();
      scl_out = 1'b1;
      gap();
      sda_out = 1'b0;
      gap();
      scl_out = 1'b0;
      gap();
   endtask
   task automatic stop();
      sda_out = 1'b0;
      gap();
      scl_out = 1'b1;
      gap();
      sda_out = 1'b1;
      gap();
   endtask
   task automatic put_byte(input logic [7:0] d, output logic nak);
      for (int i = 7; i >= 0; i--)
         send_bit(d[i]);
      take_bit(nak);
   endtask
   task automatic get_byte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         take_bit(d[i]);
      send_bit(last);
   endtask
   task automatic write_reg(input logic [7:0] a, d, output logic nak);
      logic n1, n2, n3;
      start();
      put_byte({`MCS_SLAVE_ADDR, 1'b0}, n1);
      put_byte(a, n2);
      put_byte(d, n3);
      stop();
      nak = n1 | n2 | n3;
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic nak);
      logic n1, n2, n3;
      start();
      put_byte({`MCS_SLAVE_ADDR, 1'b0}, n1);
      put_byte(a, n2);
      start();
      put_byte({`MCS_SLAVE_ADDR, 1'b1}, n3);
      get_byte(1'b1, d);
      stop();
      nak = n1 | n2 | n3;
   endtask
endmodule // mcs_host_model
`default_nettype wire

//--- dv/mcs_monitor_ctrl_bench.sv
/* self-checking bench of mcs_monitor_ctrl: bus traffic, pins, resets.
   assumes the host model and bound checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module mcs_monitor_ctrl_bench;
   logic        sys_clk_in, reset_in, rail_n, alert_ev, ovh_req, ci_ev, pin_drv;
   logic        scl, host_sda, sda_o, sda_oe_n, alert_n, pin42_o, pin42_oe_n, fan_full;
   logic        run, lowp, adc, lstart, shared, ovh_en, afc_a, afc_p, vref;
   logic [15:0] goe_n, e16;
   logic [7:0]  lfsr_q = 8'h59;
   logic [7:0]  v, a, cfg [4], val [17];
   logic [6:0]  o7;
   logic        n;
   int          err_count, check_count;
   wire         sda = host_sda & (sda_oe_n | sda_o);
   wire         pin42 = pin_drv & (pin42_oe_n | pin42_o);
   localparam logic [7:0] soft_tbl [17] = '{8'h01, 8'h05, 8'h08, 8'h0b, 8'h0d, 8'h0e,
      8'h12, 8'h18, 8'h1d, 8'h1f, 8'h20, 8'h25, 8'h3f, 8'h40, 8'h6d, 8'h6e, 8'h6f};
   mcs_monitor_ctrl DUT (
      .sys_clk_in(sys_clk_in), .reset_in(reset_in), .main_rail_reset_n_in(rail_n),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
      .alert_event_in(alert_ev), .alert_n_out(alert_n), .overheat_req_in(ovh_req),
      .pin42_in(pin42), .pin42_out(pin42_o), .pin42_oe_n_out(pin42_oe_n),
      .fan_full_speed_out(fan_full), .chassis_intrusion_in(ci_ev),
      .monitor_run_out(run), .low_power_out(lowp), .adc_enable_out(adc),
      .loop_start_out(lstart), .shared_pins_analog_out(shared), .overheat_en_out(ovh_en),
      .afc_analog_out(afc_a), .afc_pwm_out(afc_p), .vref_2v5_sel_out(vref),
      .gpio_oe_n_out(goe_n));
   mcs_host_model host (.sys_clk_in(sys_clk_in), .sda_in(sda), .scl_out(scl),
      .sda_out(host_sda));
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   function automatic logic [7:0] lfsr();
      lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      return lfsr_q;
   endfunction
   function automatic logic [7:0] def_of(input logic [7:0] r);
      case (r)
         8'h02, 8'h03: return 8'h55;
         8'h04, 8'h05: return 8'hff;
         8'h0d: return 8'h37;
         8'h0e: return 8'h50;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic in_soft(input logic [7:0] r);
      return (r >= 8'h01 && r <= 8'h0b) || (r >= 8'h18 && r <= 8'h3f) || r >= 8'h6e && r <= 8'h6f;
   endfunction
   task automatic tick(input int c);
      repeat (c) @(negedge sys_clk_in);
   endtask
   task automatic check(input logic [15:0] s, e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] r, d);
      logic k;
      host.write_reg(r, d, k);
      check(16'(k), 16'h0000);
   endtask
   task automatic rd_chk(input logic [7:0] r, e, m);
      logic [7:0] d;
      logic k;
      host.read_reg(r, d, k);
      check(16'(k), 16'h0000);
      check(16'(d & m), 16'(e));
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(3);
   endtask
   task automatic tally_and_finish();
      if (err_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      reset_in = 1'b1;
      rail_n = 1'b1;
      alert_ev = 1'b0;
      ovh_req = 1'b0;
      ci_ev = 1'b0;
      pin_drv = 1'b1;
      tick(8);
      reset_in = 1'b0;
      tick(1);
      check(goe_n, 16'hffff);
      check(16'({lowp, run, adc, alert_n, pin42_oe_n}), 16'h0013);
      foreach (soft_tbl[i]) rd_chk(soft_tbl[i], def_of(soft_tbl[i]), 8'hff);
      rd_chk(8'h02, 8'h55, 8'hff);
      // wrong slave address must be ignored
      host.start();
      host.put_byte(8'h5a, n);
      host.stop();
      check(16'(n), 16'h0001);
      for (int i = 0; i < 10; i++) begin
         v = (i < 7) ? 8'h01 << i : lfsr();
         v = v & 8'h7b;
         v[0] = i[0];
         wr(8'h00, v);
         o7 = {afc_p, afc_a, ovh_en, shared, adc, lowp, run};
         check(16'(o7), 16'({v[6:3], v[0], ~v[0], v[0]}));
         rd_chk(8'h00, v, 8'hff);
      end
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 8'hff : lfsr();
         wr(8'h07, v);
         check(16'(vref), 16'(v[2]));
         rd_chk(8'h07, v & 8'hc7, 8'hff);
      end
      wr(8'h07, 8'h00);
      for (int j = 0; j < 4; j++) begin
         cfg[j] = lfsr();
         wr(8'h08 + 8'(j), cfg[j]);
      end
      for (int k = 0; k < 16; k++)
         e16[k] = ~cfg[k / 4][(k % 4) * 2];
      check(goe_n, e16);
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 17; i++) begin
            val[i] = lfsr();
            wr(soft_tbl[i], val[i]);
         end
         if (p == 0) begin
            wr(8'h00, 8'h80);
            rd_chk(8'h00, 8'h80, 8'hff);
            wr(8'h00, 8'h00);
         end else begin
            rail_n = 1'b0;
            tick(8);
            rail_n = 1'b1;
            tick(4);
         end
         for (int i = 0; i < 17; i++) begin
            a = soft_tbl[i];
            rd_chk(a, in_soft(a) ? def_of(a) : val[i], 8'hff);
         end
         check(goe_n, 16'hffff);
      end
      pulse(ci_ev);
      rd_chk(8'h23, 8'h40, 8'h40);
      wr(8'h00, 8'h02);
      pulse(alert_ev);
      check(16'(alert_n), 16'h0000);
      wr(8'h00, 8'h06);
      check(16'(alert_n), 16'h0001);
      rd_chk(8'h23, 8'h40, 8'h40);
      wr(8'h00, 8'h02);
      check(16'(alert_n), 16'h0001);
      pulse(alert_ev);
      wr(8'h00, 8'h00);
      check(16'(alert_n), 16'h0001);
      wr(8'h00, 8'h02);
      check(16'(alert_n), 16'h0000);
      wr(8'h00, 8'h04);
      wr(8'h07, 8'h02);
      rd_chk(8'h23, 8'h00, 8'h40);
      pulse(ci_ev);
      rd_chk(8'h23, 8'h00, 8'h40);
      wr(8'h07, 8'h00);
      pulse(ci_ev);
      rd_chk(8'h23, 8'h40, 8'h40);
      wr(8'h00, 8'h10);
      ovh_req = 1'b1;
      tick(4);
      check(16'({pin42_oe_n, fan_full}), 16'h0001);
      ovh_req = 1'b0;
      tick(4);
      check(16'({pin42_oe_n, fan_full}), 16'h0002);
      pin_drv = 1'b0;
      tick(4);
      check(16'(fan_full), 16'h0001);
      wr(8'h07, 8'h01);
      tick(4);
      check(16'({pin42_oe_n, fan_full}), 16'h0002);
      ovh_req = 1'b1;
      tick(4);
      check(16'({pin42_oe_n, fan_full}), 16'h0003);
      ovh_req = 1'b0;
      pin_drv = 1'b1;
      wr(8'h00, 8'h00);
      tally_and_finish();
   end
   // cut a hung bus well past the expected run length
   initial begin
      repeat (90000) @(posedge sys_clk_in);
      err_count++;
      tally_and_finish();
   end
endmodule // mcs_monitor_ctrl_bench
`default_nettype wire
